/* watchdog_interval_timer_regs.svh */
// constants for the watchdog / interval timer: keys, field positions, reset values
// assumes inclusion by bare name from the timer module or its test bench
`ifndef WATCHDOG_INTERVAL_TIMER_REGS_SVH
`define WATCHDOG_INTERVAL_TIMER_REGS_SVH

`define WIT_KEY_COUNTER     8'h5a
`define WIT_KEY_CONTROL     8'ha5
`define WIT_CTRL_RESET      8'h00
`define WIT_COUNT_RESET     8'h00
`define WIT_BIT_ENABLE      7
`define WIT_BIT_MODE        6
`define WIT_BIT_RSTSEL      5
`define WIT_BIT_WD_FLAG     4
`define WIT_BIT_IV_FLAG     3
`define WIT_CLKSEL_MSB      2
`define WIT_CLKSEL_LSB      0
`define WIT_PRESCALE_WIDTH  12
`define WIT_RESET_PULSE_CYC 4'h4
`define WIT_STOP_VALUE      8'h00

`endif

/* watchdog_interval_timer_pkg.sv */
// types for the watchdog / interval timer
// assumes the constants header sits in the same folder
`default_nettype none
package watchdog_interval_timer_pkg;
	typedef enum logic [1:0] {
		st_idle     = 2'b00,
		st_settling = 2'b01,
		st_running  = 2'b10
	} timer_state_t;

	typedef enum logic [1:0] {
		acc_byte = 2'b00,
		acc_word = 2'b01,
		acc_long = 2'b10
	} access_size_t;
endpackage
`default_nettype wire

/* watchdog_interval_timer.sv */
// watchdog / interval timer with keyed word writes and pll settling timing
// assumes the cpu write port, the frequency control write strobe and
// the count-clock prescaler all sit on core_clk
//
// Function
// R1: software uses the timer for settling only when the pll multiplier changes.
// R2: software clears timer enable before any frequency change.
// R3: software loads clock select and count so overflow outlasts settling.
// R4: frequency control write halts the processor and starts counting.
// R5: settling overflow resumes clock and processor, watchdog flag stays clear.
// R6: after settling overflow the counter stops at 00 or 01.
// R7: software reads counter as 00 before writing it after change.
// R8: watchdog setup: mode select 1, reset type, clock, initial count.
// R9: enable with mode select 1 counts in watchdog mode.
// R10: software rewrites counter to 00 periodically in watchdog mode.
// R11: watchdog overflow sets its flag, issues selected reset, keeps counting.
// R12: interval setup: mode select 0, clock select, initial count.
// R13: enable with mode select 0 counts in interval mode.
// R14: interval overflow sets its flag, requests interrupt, keeps counting.
// R15: software waits 30 bus clocks before cache use after a change.
// R16: writes are keyed words, 5a counter, a5 control; others ignored.
// R17: clock select divides by 1,4,16,32,64,256,1024,4096.
// R18: reset select picks power-on when 0, manual when 1.
// R19: enable low stops counting and keeps the counter value.
// R20: overflow is a wrap from ff to 00 on a count tick.
`timescale 1ns/1ps
`default_nettype none
`include "watchdog_interval_timer_regs.svh"

module watchdog_interval_timer #(
	parameter int COUNT_WIDTH = 8
) (
	// clock and reset
	input  wire logic                   core_clk,
	input  wire logic                   reset,
	// cpu write port
	input  wire logic                   write_strobe,
	input  wire logic [1:0]             write_size,
	input  wire logic                   write_sel_counter,
	input  wire logic                   write_sel_control,
	input  wire logic [15:0]            write_data,
	// clock pulse generator side
	input  wire logic                   frequency_control_write,
	output logic                        processor_halt,
	// readback
	output logic [COUNT_WIDTH-1:0]      timer_counter,
	output logic [7:0]                  timer_control_status,
	// reset and interrupt requests
	output logic                        power_on_reset_req,
	output logic                        manual_reset_req,
	output logic                        interval_irq
);
	// decodes the divider tap for a clock select code
	function automatic logic tick_for(input logic [2:0] sel,
		input logic [`WIT_PRESCALE_WIDTH-1:0] pre);
		logic [`WIT_PRESCALE_WIDTH-1:0] mask;
		mask = '0;
		unique case (sel) // R17
			3'h0: mask = 12'h000;
			3'h1: mask = 12'h003;
			3'h2: mask = 12'h00f;
			3'h3: mask = 12'h01f;
			3'h4: mask = 12'h03f;
			3'h5: mask = 12'h0ff;
			3'h6: mask = 12'h3ff;
			3'h7: mask = 12'hfff;
		endcase
		return (pre & mask) == mask;
	endfunction

	// sequencer, divider, counter and control state
	watchdog_interval_timer_pkg::timer_state_t state, next_state;
	logic [`WIT_PRESCALE_WIDTH-1:0]            prescale, next_prescale;
	logic [COUNT_WIDTH-1:0]                    next_counter;
	logic [7:0]                                next_control;
	// request stretcher state
	logic [3:0]                                pulse_cnt, next_pulse_cnt;
	logic                                      pulse_manual, next_pulse_manual;
	logic                                      next_por_req, next_manual_req;
	logic                                      next_irq;
	// decoded strobes
	logic                                      counting, tick, wrap, word_ok;
	logic                                      counter_write, control_write;
	logic                                      watchdog_wrap, interval_wrap;

	// only keyed word writes reach the registers; byte and long writes are dropped
	assign word_ok = write_strobe &&
		(write_size == watchdog_interval_timer_pkg::acc_word); // R16
	// a wrong key is taken as a runaway program and ignored, not flagged
	assign counter_write = word_ok && write_sel_counter &&
		(write_data[15:8] == `WIT_KEY_COUNTER); // R16
	assign control_write = word_ok && write_sel_control &&
		(write_data[15:8] == `WIT_KEY_CONTROL); // R16

	// the divider only runs while the counter may count
	assign counting = (state == watchdog_interval_timer_pkg::st_settling) ||
		(state == watchdog_interval_timer_pkg::st_running);
	assign tick = counting &&
		tick_for(timer_control_status[`WIT_CLKSEL_MSB:`WIT_CLKSEL_LSB], prescale); // R17
	assign wrap = tick && (timer_counter == {COUNT_WIDTH{1'b1}}); // R20

	// settling wraps are split off here so that they raise neither flag nor request
	assign watchdog_wrap = wrap && (state == watchdog_interval_timer_pkg::st_running) &&
		timer_control_status[`WIT_BIT_MODE]; // R11
	assign interval_wrap = wrap && (state == watchdog_interval_timer_pkg::st_running) &&
		!timer_control_status[`WIT_BIT_MODE]; // R14

	// the halt is a decode of the state register, so it cannot glitch
	assign processor_halt = (state == watchdog_interval_timer_pkg::st_settling); // R4

	// divider next value: cleared while stopped so every start sees a full period
	always_comb begin
		next_prescale = '0;
		if (counting) begin
			next_prescale = prescale + 1'b1;
		end
	end

	// divider register
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			prescale <= '0;
		end else begin
			prescale <= next_prescale;
		end
	end

	// counter, control register and sequencer next values
	always_comb begin
		next_state   = state;
		next_counter = timer_counter;
		next_control = timer_control_status;
		// a count tick moves the counter; a keyed write in the same cycle wins
		if (tick) begin
			next_counter = timer_counter + 1'b1; // R20
		end
		if (counter_write) begin
			next_counter = write_data[COUNT_WIDTH-1:0]; // R16
		end
		if (control_write) begin
			// software can only clear a flag: writing 0 clears it, 1 keeps it
			next_control = write_data[7:0]; // R16
			next_control[`WIT_BIT_WD_FLAG] = timer_control_status[`WIT_BIT_WD_FLAG] &
				write_data[`WIT_BIT_WD_FLAG];
			next_control[`WIT_BIT_IV_FLAG] = timer_control_status[`WIT_BIT_IV_FLAG] &
				write_data[`WIT_BIT_IV_FLAG];
		end
		// hardware sets come last, so a set beats a clear in the same cycle
		if (watchdog_wrap) begin
			next_control[`WIT_BIT_WD_FLAG] = 1'b1; // R11
		end
		if (interval_wrap) begin
			next_control[`WIT_BIT_IV_FLAG] = 1'b1; // R14
		end
		unique case (state)
			watchdog_interval_timer_pkg::st_idle: begin
				// a frequency change takes the counter from idle, ahead of the enable; while running it is ignored
				if (frequency_control_write) begin
					next_state = watchdog_interval_timer_pkg::st_settling; // R4
				end else if (timer_control_status[`WIT_BIT_ENABLE]) begin
					next_state = watchdog_interval_timer_pkg::st_running; // R9 R13
				end
			end
			watchdog_interval_timer_pkg::st_settling: begin
				// the counter parks at the stop value and no flag is raised
				if (wrap) begin
					next_state   = watchdog_interval_timer_pkg::st_idle; // R5
					next_counter = COUNT_WIDTH'(`WIT_STOP_VALUE); // R6
				end
			end
			watchdog_interval_timer_pkg::st_running: begin
				// clearing the enable stops at once and leaves the count where it is
				if (!next_control[`WIT_BIT_ENABLE]) begin
					next_state = watchdog_interval_timer_pkg::st_idle; // R19
				end
			end
			default: next_state = watchdog_interval_timer_pkg::st_idle;
		endcase
	end

	// state, counter and control registers; the external reset clears all three
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			state                <= watchdog_interval_timer_pkg::st_idle;
			timer_counter        <= COUNT_WIDTH'(`WIT_COUNT_RESET);
			timer_control_status <= `WIT_CTRL_RESET;
		end else begin
			state                <= next_state;
			timer_counter        <= next_counter;
			timer_control_status <= next_control;
		end
	end

	// request stretcher: a reset request stands for a fixed count of cycles
	always_comb begin
		next_pulse_cnt    = pulse_cnt;
		next_pulse_manual = pulse_manual;
		if (pulse_cnt != 4'h0) begin
			next_pulse_cnt = pulse_cnt - 4'h1;
		end
		// the reset type is latched at the wrap, so a later write cannot swap it mid-pulse
		if (watchdog_wrap) begin
			next_pulse_cnt    = `WIT_RESET_PULSE_CYC; // R11
			next_pulse_manual = timer_control_status[`WIT_BIT_RSTSEL]; // R18
		end
		next_por_req    = (next_pulse_cnt != 4'h0) && !next_pulse_manual; // R11 R18
		next_manual_req = (next_pulse_cnt != 4'h0) && next_pulse_manual; // R11 R18
		next_irq        = interval_wrap; // R14
	end

	// request registers, so the reset logic and interrupt controller see clean levels
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			pulse_cnt          <= 4'h0;
			pulse_manual       <= 1'b0;
			power_on_reset_req <= 1'b0;
			manual_reset_req   <= 1'b0;
			interval_irq       <= 1'b0;
		end else begin
			pulse_cnt          <= next_pulse_cnt;
			pulse_manual       <= next_pulse_manual;
			power_on_reset_req <= next_por_req;
			manual_reset_req   <= next_manual_req;
			interval_irq       <= next_irq;
		end
	end
endmodule

`default_nettype wire

/* watchdog_interval_timer_properties.sv */
// port-level assertions for the watchdog / interval timer
// assumes it is bound into the timer top module
`timescale 1ns/1ps
`default_nettype none
module wit_checker #(
	parameter int COUNT_WIDTH = 8
) (
	// watched ports
	input wire logic                   core_clk,
	input wire logic                   reset,
	input wire logic                   write_strobe,
	input wire logic                   frequency_control_write,
	input wire logic                   processor_halt,
	input wire logic [COUNT_WIDTH-1:0] timer_counter,
	input wire logic [7:0]             timer_control_status,
	input wire logic                   power_on_reset_req,
	input wire logic                   manual_reset_req,
	input wire logic                   interval_irq
);
	// status bits by meaning
	wire logic en = timer_control_status[7];
	wire logic wd = timer_control_status[6];
	wire logic rsel = timer_control_status[5];
	wire logic wd_flag = timer_control_status[4];
	wire logic iv_flag = timer_control_status[3];
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	halt_start_a: assert property (frequency_control_write && !processor_halt && !en
		|=> processor_halt) else $error("halt missing after freq write");
	settle_stop_a: assert property ($fell(processor_halt) |-> timer_counter == 0 && !wd_flag)
		else $error("bad settling stop");
	por_pulse_a: assert property ($rose(power_on_reset_req) |-> power_on_reset_req[*4]
		##1 !power_on_reset_req) else $error("power-on request width wrong");
	por_kind_a: assert property ($rose(power_on_reset_req) |-> wd && !rsel)
		else $error("power-on request in wrong setting");
	manual_kind_a: assert property ($rose(manual_reset_req) |-> wd && rsel)
		else $error("manual request in wrong setting");
	irq_flag_a: assert property (interval_irq |-> !wd ##[0:1] iv_flag)
		else $error("irq without interval flag");
	irq_single_a: assert property (interval_irq |=> !interval_irq) else $error("irq too long");
	hold_stop_a: assert property ((!en && !processor_halt && !write_strobe
		&& !frequency_control_write)[*2] |=> $stable(timer_counter)) else $error("counter moved");
	wrap_irq_a: assert property ($past(timer_counter) == 8'hff && timer_counter == 0 && en
		&& !wd && !$past(write_strobe) && !$past(processor_halt) |-> ##[0:1] interval_irq)
		else $error("wrap gave no irq");
endmodule
bind watchdog_interval_timer wit_checker #(.COUNT_WIDTH(COUNT_WIDTH)) chk (.core_clk, .reset,
	.write_strobe, .frequency_control_write, .processor_halt, .timer_counter,
	.timer_control_status, .power_on_reset_req, .manual_reset_req, .interval_irq);
`default_nettype wire

/* timer_far_side.sv */
// interrupt controller and reset logic facing the timer
// assumes requests are synchronous to core_clk
`timescale 1ns/1ps
`default_nettype none
module timer_far_side (
	// requests from the timer
	input wire logic core_clk,
	input wire logic interval_irq,
	input wire logic power_on_reset_req,
	input wire logic manual_reset_req,
	// request cycles taken
	output var int   n_irq,
	output var int   n_por,
	output var int   n_man
);
	// counts cycles, so a reset pulse adds its width
	always @(posedge core_clk) begin
		n_irq <= n_irq + int'(interval_irq);
		n_por <= n_por + int'(power_on_reset_req);
		n_man <= n_man + int'(manual_reset_req);
	end
endmodule
`default_nettype wire

/* watchdog_interval_timer_test.sv */
// self-checking bench for the watchdog / interval timer
// assumes design files and far-side model compile first
`timescale 1ns/1ps
`default_nettype none
`include "watchdog_interval_timer_regs.svh"
`define CHK(n, e, a) begin n_compared++; if ((a) !== (e)) begin failures++; \
	$display("CHECK FAILED %s expected %h seen %h", n, e, a); end end
module watchdog_interval_timer_test;
	logic        core_clk = 0, reset = 1, write_strobe = 0, write_sel_counter = 0;
	logic        write_sel_control = 0, frequency_control_write = 0, processor_halt;
	logic        power_on_reset_req, manual_reset_req, interval_irq;
	logic [1:0]  write_size = 0;
	logic [15:0] write_data = 0;
	logic [7:0]  timer_counter, timer_control_status, v, seed = 8'h27;
	int          failures = 0, n_compared = 0, n_irq, n_por, n_man, t, kp, km;
	watchdog_interval_timer DUT (.core_clk, .reset, .write_strobe, .write_size,
		.write_sel_counter, .write_sel_control, .write_data, .frequency_control_write,
		.processor_halt, .timer_counter, .timer_control_status, .power_on_reset_req,
		.manual_reset_req, .interval_irq);
	timer_far_side far (.core_clk, .interval_irq, .power_on_reset_req, .manual_reset_req,
		.n_irq, .n_por, .n_man);
	always #5 core_clk = ~core_clk;
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	function automatic int div(input int c);
		int d[8] = '{1, 4, 16, 32, 64, 256, 1024, 4096};
		return d[c];
	endfunction
	// one write held for a single edge; size 1 is the only one taken
	task automatic wr(input logic ctl, input logic [1:0] sz, input logic [7:0] key, val);
		@(posedge core_clk) #1;
		write_strobe = 1;
		write_sel_control = ctl;
		write_sel_counter = !ctl;
		write_size = sz;
		write_data = {key, val};
		@(posedge core_clk) #1;
		write_strobe = 0;
	endtask
	task automatic close_out;
		$display("compared %0d, mismatched %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	// bounded wait; t ends as the edges spent
	task automatic wait_cnt(input logic [7:0] x);
		t = 0;
		while (timer_counter !== x && t < 9000) begin
			@(posedge core_clk) #1;
			t++;
		end
		if (t >= 9000) begin failures++; close_out; end
	endtask
	initial begin
		repeat (5) @(posedge core_clk);
		#1 reset = 0;
		// wrong size or key must change nothing
		wr(1, 2'h0, `WIT_KEY_CONTROL, 8'h80);
		wr(1, 2'h2, `WIT_KEY_CONTROL, 8'h80);
		wr(1, 2'h1, `WIT_KEY_COUNTER, 8'h80);
		wr(0, 2'h1, `WIT_KEY_CONTROL, 8'h80);
		`CHK("refused control", 8'h00, timer_control_status)
		`CHK("refused counter", 8'h00, timer_counter)
		repeat (8) begin
			seed = lfsr(seed);
			wr(0, 2'h1, `WIT_KEY_COUNTER, seed);
			wr(0, 2'h1, {seed[7:1], 1'b1}, ~seed);
			`CHK("keyed load", seed, timer_counter)
		end
		$display("key test done");
		// tick spacing for every clock-select code
		for (int c = 0; c < 8; c++) begin
			wr(1, 2'h1, `WIT_KEY_CONTROL, 8'h00);
			wr(0, 2'h1, `WIT_KEY_COUNTER, 8'h00);
			wr(1, 2'h1, `WIT_KEY_CONTROL, 8'h80 | 8'(c));
			wait_cnt(8'h01);
			wait_cnt(8'h02);
			`CHK("tick spacing", div(c), t)
		end
		$display("clock select test done");
		// interval wrap, then disable holds the count
		wr(1, 2'h1, `WIT_KEY_CONTROL, 8'h00);
		wr(0, 2'h1, `WIT_KEY_COUNTER, 8'hfc);
		kp = n_irq;
		wr(1, 2'h1, `WIT_KEY_CONTROL, 8'h80);
		wait_cnt(8'h03);
		`CHK("interval flag", 1'b1, timer_control_status[3])
		`CHK("irq pulses", kp + 1, n_irq)
		wr(1, 2'h1, `WIT_KEY_CONTROL, 8'h08);
		repeat (2) @(posedge core_clk);
		#1 v = timer_counter;
		repeat (30) @(posedge core_clk);
		#1 `CHK("held count", v, timer_counter)
		$display("interval test done");
		// watchdog: refresh keeps it quiet, then overflow with each reset type
		for (int r = 0; r < 2; r++) begin
			wr(1, 2'h1, `WIT_KEY_CONTROL, 8'h00);
			wr(0, 2'h1, `WIT_KEY_COUNTER, 8'h00);
			{kp, km} = {n_por, n_man};
			wr(1, 2'h1, `WIT_KEY_CONTROL, 8'hc0 | 8'(r << 5));
			repeat (3) begin
				repeat (200) @(posedge core_clk);
				wr(0, 2'h1, `WIT_KEY_COUNTER, 8'h00);
			end
			`CHK("refreshed", kp + km, n_por + n_man)
			wr(0, 2'h1, `WIT_KEY_COUNTER, 8'hf0);
			wait_cnt(8'h08);
			`CHK("watchdog flag", 1'b1, timer_control_status[4])
			`CHK("power-on cycles", kp + (r ? 0 : 4), n_por)
			`CHK("manual cycles", km + (r ? 4 : 0), n_man)
		end
		$display("watchdog test done");
		// settling with watchdog mode armed but disabled: no flag, no reset request
		wr(1, 2'h1, `WIT_KEY_CONTROL, 8'h40);
		wr(0, 2'h1, `WIT_KEY_COUNTER, 8'hf8);
		{kp, km} = {n_por, n_man};
		frequency_control_write = 1;
		@(posedge core_clk) #1 frequency_control_write = 0;
		`CHK("halted", 1'b1, processor_halt)
		wait_cnt(8'h00);
		repeat (30) @(posedge core_clk);
		#1 `CHK("resumed", 1'b0, processor_halt)
		`CHK("stop value", 8'h00, timer_counter)
		`CHK("no watchdog flag", 1'b0, timer_control_status[4])
		`CHK("no settling reset", kp + km, n_por + n_man)
		seed = lfsr(seed);
		wr(0, 2'h1, `WIT_KEY_COUNTER, seed);
		`CHK("load after change", seed, timer_counter)
		$display("settling test done");
		close_out;
	end
endmodule
`default_nettype wire
